// ==== logic/timer0_core.sv ====
// Purpose: timer/counter 0 registers, counter, capture, compare
// Assumes: CPU keeps 16-bit access order and masks interrupts
// Notes:   read data appear the cycle after the read strobe
`timescale 1ns/1ps

// How it works
// [RL1] one temporary high byte shared by all 16-bit registers
// [RL2] software masks interrupts across each two-byte access
// [RL3] a low-byte write leaves the temporary byte unchanged
// [RL4] width select bit 7 set gives a 16-bit counter, else 8-bit
// [RL5] in 16-bit mode compare B:A form one 16-bit compare value
// [RL6] capture enable bit 6 puts the timer into capture mode
// [RL7] filter bit 5 needs four equal samples to move its output
// [RL8] the filter adds four system clock cycles of latency
// [RL9] edge select bit 4: zero falling edge, one rising edge
// [RL10] a capture edge copies the counter into the capture register
// [RL11] a capture sets the flag; it requests only when enabled
// [RL12] source bit 3 set feeds the comparator through filter and edge
// [RL13] source bit clear leaves the comparator unconnected
// [RL14] software sets the capture interrupt enable for comparator use
// [RL15] control bits 2:1 read zero and ignore writes
// [RL16] mode bit 0 picks free running or clear on compare
// [RL17] low byte gives direct counter access, lower half in 16-bit
// [RL18] a counter low write blocks the match at the next tick
// [RL19] software avoids rewriting the counter while it runs
// [RL20] low-byte access does the whole 16-bit transfer at once
// [RL21] software writes high then low, reads low then high
// [RL22] compare reads bypass temporary; 16-bit capture reads use it
// [RL23] a compare match sets its flag at the following tick
module timer0_core (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // cpu i/o bus
    input  timer0_pkg::io_req_s    ioReq,
    output logic [7:0]             ioRdData,
    // timer clock enable and capture sources
    input  wire logic              tickEn,
    input  wire logic              captureInputPin,
    input  wire logic              comparatorOut,
    // status toward the core
    output logic [7:0]             irqRequest,
    output logic [15:0]            countReg
);
    import timer0_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ctrl_s       ctrlReg;
    logic [7:0]  tempReg;
    logic [7:0]  cmpAReg;
    logic [7:0]  cmpBReg;
    logic [7:0]  flagsReg;
    logic [7:0]  flags_next;
    logic [7:0]  maskReg;
    logic        blockReg;
    logic [15:0] countNext;
    logic [15:0] countSum;
    logic [15:0] wrapVal;
    logic [15:0] topVal;
    logic        topHit;
    logic        wrapHit;
    logic        ovfHit;
    logic        capStrobe;
    logic        capHit;
    logic        capture16;
    logic [7:0]  flagSet;
    logic [7:0]  flagClr;
    logic [7:0]  rdMux;
    logic [1:0]  matchOn;
    logic [1:0]  pend;
    logic [1:0]  setHit;
    logic [15:0] cmpVal [2];

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic wrCtrl;
    logic wrCntLow;
    logic wrCntHigh;
    logic wrCmpA;
    logic wrCmpB;
    logic wrFlags;
    logic wrMask;
    logic rdCntLow;
    logic rdCmpA;

    // write strobes per register, read strobes for count low and compare a
    assign wrCtrl    = ioReq.wr && (ioReq.addr == ADDR_CTRL_A);
    assign wrCntLow  = ioReq.wr && (ioReq.addr == ADDR_CNT_LOW);
    assign wrCntHigh = ioReq.wr && (ioReq.addr == ADDR_CNT_HIGH);
    assign wrCmpA    = ioReq.wr && (ioReq.addr == ADDR_CMP_A);
    assign wrCmpB    = ioReq.wr && (ioReq.addr == ADDR_CMP_B);
    assign wrFlags   = ioReq.wr && (ioReq.addr == ADDR_FLAGS);
    assign wrMask    = ioReq.wr && (ioReq.addr == ADDR_MASK);
    assign rdCntLow  = ioReq.rd && (ioReq.addr == ADDR_CNT_LOW);
    assign rdCmpA    = ioReq.rd && (ioReq.addr == ADDR_CMP_A);

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // reserved bits masked on write so they stay zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrlReg <= ctrl_s'(CTRL_A_RESET);
        end else if (wrCtrl) begin
            ctrlReg <= ctrl_s'(ioReq.wrData & CTRL_A_WMASK); // see [RL15]
        end
    end

    // 16-bit capture routes capture reads through temp
    assign capture16 = ctrlReg.widthSelect && ctrlReg.captureModeEnable;

    // ------------------------------------------------------------
    // shared temporary high byte
    // ------------------------------------------------------------
    // high writes park data; low reads fetch the high half
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tempReg <= BYTE_RESET;
        end else if (wrCntHigh || (wrCmpB && ctrlReg.widthSelect)) begin
            tempReg <= ioReq.wrData; // see [RL1]
        end else if (rdCntLow) begin
            tempReg <= countReg[15:8]; // see [RL1] [RL20]
        end else if (rdCmpA && capture16) begin
            tempReg <= cmpBReg; // see [RL22]
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // wrap point and top value per width and mode
    always_comb begin
        wrapVal  = ctrlReg.widthSelect ? MAX16 : MAX8; // see [RL4]
        topVal   = ctrlReg.widthSelect ? {cmpBReg, cmpAReg}
                                       : {BYTE_RESET, cmpAReg};
        topHit   = ctrlReg.waveformModeSelect
                   && (countReg == topVal); // see [RL16]
        wrapHit  = (countReg == wrapVal);
        countSum = countReg + 16'h0001;
        if (topHit || wrapHit) begin
            countNext = CNT_RESET;
        end else if (ctrlReg.widthSelect) begin
            countNext = countSum;
        end else begin
            countNext = {BYTE_RESET, countSum[7:0]};
        end
    end

    // overflow only at the max wrap, never at a compare top clear
    assign ovfHit = tickEn && !wrCntLow && wrapHit && !topHit;

    // cpu low write loads whole count, else count on tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            countReg <= CNT_RESET;
        end else if (wrCntLow) begin
            if (ctrlReg.widthSelect) begin
                countReg <= {tempReg, ioReq.wrData}; // see [RL17] [RL20]
            end else begin
                countReg <= {BYTE_RESET, ioReq.wrData}; // see [RL17]
            end
        end else if (tickEn) begin
            countReg <= countNext; // see [RL4] [RL16]
        end
    end

    // ------------------------------------------------------------
    // capture front end
    // ------------------------------------------------------------
    capture_front_end u_capture (
        .clk       (clk),
        .rst_b     (rst_b),
        .pinIn     (captureInputPin),
        .compIn    (comparatorOut),
        .compSrc   (ctrlReg.comparatorCaptureSource), // see [RL12]
        .filterOn  (ctrlReg.captureNoiseFilter),      // see [RL7]
        .edgeRise  (ctrlReg.captureEdgeSelect),       // see [RL9]
        .strobeReg (capStrobe)
    );

    assign capHit = capStrobe && ctrlReg.captureModeEnable; // see [RL6]

    // ------------------------------------------------------------
    // compare registers, also the capture register
    // ------------------------------------------------------------
    // capture wins over a cpu write in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmpAReg <= BYTE_RESET;
            cmpBReg <= BYTE_RESET;
        end else if (capHit) begin
            cmpAReg <= countReg[7:0]; // see [RL10]
            if (ctrlReg.widthSelect) begin
                cmpBReg <= countReg[15:8];
            end
        end else if (wrCmpA) begin
            cmpAReg <= ioReq.wrData;
            if (ctrlReg.widthSelect) begin
                cmpBReg <= tempReg; // see [RL20] [RL3]
            end
        end else if (wrCmpB && !ctrlReg.widthSelect) begin
            cmpBReg <= ioReq.wrData;
        end
    end

    // ------------------------------------------------------------
    // compare channels
    // ------------------------------------------------------------
    // counter write blocks the match seen at the next tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            blockReg <= 1'b0;
        end else if (wrCntLow) begin
            blockReg <= 1'b1; // see [RL18]
        end else if (tickEn) begin
            blockReg <= 1'b0;
        end
    end

    // channel b silent in 16-bit mode, both silent in capture
    always_comb begin
        matchOn[0] = !ctrlReg.captureModeEnable;
        matchOn[1] = !ctrlReg.captureModeEnable && !ctrlReg.widthSelect;
        cmpVal[0]  = ctrlReg.widthSelect ? {cmpBReg, cmpAReg}
                                         : {BYTE_RESET, cmpAReg}; // see [RL5]
        cmpVal[1]  = {BYTE_RESET, cmpBReg};
    end

    // one compare unit per channel
    for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
        compare_match_unit u_match (
            .clk        (clk),
            .rst_b      (rst_b),
            .tickEn     (tickEn),
            .matchOn    (matchOn[ch]),
            .blockMatch (blockReg),
            .countVal   (countReg),
            .cmpVal     (cmpVal[ch]),
            .pendReg    (pend[ch]),
            .setReg     (setHit[ch])
        );
    end

    // ------------------------------------------------------------
    // flags and mask
    // ------------------------------------------------------------
    // events set, written ones clear, set wins
    always_comb begin
        flagSet           = BYTE_RESET;
        flagSet[FLG_CAP]  = capHit; // see [RL11]
        flagSet[FLG_OVF]  = ovfHit;
        flagSet[FLG_CMPA] = setHit[0]; // see [RL23]
        flagSet[FLG_CMPB] = setHit[1];
        flagClr           = wrFlags ? ioReq.wrData : BYTE_RESET;
        flags_next        = ((flagsReg & ~flagClr) | flagSet) & FLAG_MASK;
    end

    // flag register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flagsReg <= BYTE_RESET;
        end else begin
            flagsReg <= flags_next;
        end
    end

    // mask register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            maskReg <= BYTE_RESET;
        end else if (wrMask) begin
            maskReg <= ioReq.wrData & FLAG_MASK;
        end
    end

    // requests only where the enable is set
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqRequest <= BYTE_RESET;
        end else begin
            irqRequest <= flagsReg & maskReg; // see [RL11]
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // read mux, unmapped reads return zero
    always_comb begin
        unique case (ioReq.addr)
            ADDR_CTRL_A:   rdMux = ctrlReg; // see [RL15]
            ADDR_CNT_LOW:  rdMux = countReg[7:0]; // see [RL17]
            ADDR_CNT_HIGH: rdMux = tempReg;
            ADDR_CMP_A:    rdMux = cmpAReg;
            ADDR_CMP_B:    rdMux = capture16 ? tempReg
                                             : cmpBReg; // see [RL22]
            ADDR_FLAGS:    rdMux = flagsReg;
            ADDR_MASK:     rdMux = maskReg;
            default:       rdMux = BYTE_RESET;
        endcase
    end

    // read data held until the next read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ioRdData <= BYTE_RESET;
        end else if (ioReq.rd) begin
            ioRdData <= rdMux;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_high_wr;
        wrCntHigh && !ioReq.rd;
    endsequence
    sequence s_low_wr;
        wrCntLow && ctrlReg.widthSelect;
    endsequence

    a_temp_park : assert property (@(posedge clk) disable iff (!rst_b)
        wrCntHigh |=> tempReg == $past(ioReq.wrData)) // see [RL1]
        else $error("high write did not reach temp byte");
    a_temp_keep : assert property (@(posedge clk) disable iff (!rst_b)
        wrCntLow |=> $stable(tempReg)) // see [RL3]
        else $error("temp byte changed on low write");
    a_pair_write : assert property (@(posedge clk) disable iff (!rst_b)
        s_high_wr ##1 s_low_wr |=>
        countReg == {$past(tempReg), $past(ioReq.wrData)}) // see [RL20]
        else $error("16-bit counter write not atomic");
    a_width_eight : assert property (@(posedge clk) disable iff (!rst_b)
        !ctrlReg.widthSelect && tickEn && !wrCntLow |=>
        countReg[15:8] == BYTE_RESET) // see [RL4]
        else $error("8-bit counter has a high byte");
    a_capture_copy : assert property (@(posedge clk) disable iff (!rst_b)
        capHit && ctrlReg.widthSelect |=>
        {cmpBReg, cmpAReg} == $past(countReg) && flagsReg[FLG_CAP])
        else $error("capture did not copy count and set flag"); // see [RL10]
    a_reserved_zero : assert property (@(posedge clk) disable iff (!rst_b)
        ctrlReg.reserved == 2'b00) // see [RL15]
        else $error("reserved control bits not zero");
    a_block_write : assert property (@(posedge clk) disable iff (!rst_b)
        wrCntLow ##1 (!tickEn)[*2] ##1 tickEn |=> !pend[0] && !pend[1])
        else $error("compare match not blocked after write"); // see [RL18]
    a_flag_follow : assert property (@(posedge clk) disable iff (!rst_b)
        setHit[0] |=> flagsReg[FLG_CMPA]) // see [RL23]
        else $error("compare a flag not set");
    a_irq_gate : assert property (@(posedge clk) disable iff (!rst_b)
        flagsReg[FLG_CAP] && !maskReg[FLG_CAP] |=> !irqRequest[FLG_CAP])
        else $error("capture request without enable"); // see [RL11]
endmodule : timer0_core

// ==== common/timer0_pkg.sv ====
// Purpose: shared constants and carriers for timer/counter 0
// Assumes: 8-bit I/O bus with 6-bit register addresses
// Notes:   offsets, field positions, reset values and counts
package timer0_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_CTRL_A   = 6'h15;
    localparam logic [5:0] ADDR_CNT_HIGH = 6'h14;
    localparam logic [5:0] ADDR_CNT_LOW  = 6'h12;
    localparam logic [5:0] ADDR_CMP_A    = 6'h13;
    localparam logic [5:0] ADDR_CMP_B    = 6'h11;
    localparam logic [5:0] ADDR_FLAGS    = 6'h38;
    localparam logic [5:0] ADDR_MASK     = 6'h39;
    // ------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------
    localparam int FLG_CAP  = 0;
    localparam int FLG_OVF  = 1;
    localparam int FLG_CMPB = 3;
    localparam int FLG_CMPA = 4;
    localparam logic [7:0] CTRL_A_WMASK = 8'hF9;
    localparam logic [7:0] FLAG_MASK    = 8'h1B;
    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_A_RESET = 8'h00;
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [15:0] MAX8         = 16'h00FF;
    localparam logic [15:0] MAX16        = 16'hFFFF;
    localparam int          FILTER_SAMPLES = 4;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wrData;
        logic       wr;
        logic       rd;
    } io_req_s;
    typedef struct packed {
        logic       widthSelect;
        logic       captureModeEnable;
        logic       captureNoiseFilter;
        logic       captureEdgeSelect;
        logic       comparatorCaptureSource;
        logic [1:0] reserved;
        logic       waveformModeSelect;
    } ctrl_s;
endpackage : timer0_pkg

// ==== logic/compare_match_unit.sv ====
// Purpose: one compare channel with delayed flag set and blocking
// Assumes: tickEn is the prescaled timer clock enable
// Notes:   setReg pulses one cycle at the tick after the match
`timescale 1ns/1ps
module compare_match_unit (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // timer side
    input  wire logic        tickEn,
    input  wire logic        matchOn,
    input  wire logic        blockMatch,
    input  wire logic [15:0] countVal,
    input  wire logic [15:0] cmpVal,
    // flag side
    output logic             pendReg,
    output logic             setReg
);
    import timer0_pkg::*;

    // match seen at a tick, held until the next tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pendReg <= 1'b0;
        end else if (tickEn) begin
            pendReg <= matchOn && (countVal == cmpVal) && !blockMatch;
        end
    end

    // flag set strobe one timer clock later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            setReg <= 1'b0;
        end else begin
            setReg <= tickEn && pendReg; // see [RL23]
        end
    end

    a_match_next : assert property (@(posedge clk) disable iff (!rst_b)
        tickEn && pendReg |=> setReg) // see [RL23]
        else $error("compare flag not set at next tick");
    a_block_kills : assert property (@(posedge clk) disable iff (!rst_b)
        tickEn && blockMatch |=> !pendReg) // see [RL18]
        else $error("blocked compare match still pending");
endmodule : compare_match_unit

// ==== logic/capture_front_end.sv ====
// Purpose: capture source select, noise filter and edge detect
// Assumes: pin and comparator inputs synchronous to clk
// Notes:   filter adds four cycles; strobe is a one-cycle pulse
`timescale 1ns/1ps
module capture_front_end (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // sources
    input  wire logic pinIn,
    input  wire logic compIn,
    // settings
    input  wire logic compSrc,
    input  wire logic filterOn,
    input  wire logic edgeRise,
    // event
    output logic      strobeReg
);
    import timer0_pkg::*;

    logic                      srcBit;
    logic [FILTER_SAMPLES-1:0] histReg;
    logic                      filtReg;
    logic                      levelBit;
    logic                      prevReg;

    // comparator reaches the logic only when selected
    assign srcBit   = compSrc ? compIn : pinIn; // see [RL12] [RL13]
    assign levelBit = filterOn ? filtReg : histReg[0];

    // sample history, newest in bit 0
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            histReg <= '0;
        end else begin
            histReg <= {histReg[FILTER_SAMPLES-2:0], srcBit};
        end
    end

    // output moves only on four equal samples
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            filtReg <= 1'b0;
        end else if (&histReg) begin
            filtReg <= 1'b1; // see [RL7] [RL8]
        end else if (~|histReg) begin
            filtReg <= 1'b0;
        end
    end

    // edge detector on the chosen level
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prevReg   <= 1'b0;
            strobeReg <= 1'b0;
        end else begin
            prevReg   <= levelBit;
            strobeReg <= edgeRise ? (levelBit && !prevReg)
                                  : (!levelBit && prevReg); // see [RL9]
        end
    end

    a_filter_steady : assert property (@(posedge clk) disable iff (!rst_b)
        !(&histReg) && (|histReg) |=> $stable(filtReg)) // see [RL7]
        else $error("filter output moved without four equal samples");
    a_comp_isolated : assert property (@(posedge clk) disable iff (!rst_b)
        !compSrc |=> histReg[0] == $past(pinIn)) // see [RL13]
        else $error("comparator leaked into capture path");
    a_edge_select : assert property (@(posedge clk) disable iff (!rst_b)
        strobeReg |-> ($past(edgeRise) == $past(levelBit))) // see [RL9]
        else $error("capture strobe on wrong edge");
endmodule : capture_front_end

// ==== bench/cpu_bus_model.sv ====
// Purpose: cpu model on the 8-bit register bus
// Assumes: strobes launched by non-blocking assignment at clk rise
// Notes:   16-bit pairs are never split by another access
`timescale 1ns/1ps
module cpu_bus_model (
    // clock
    input  wire logic           clk,
    // register bus
    output timer0_pkg::io_req_s ioReq,
    input  wire logic [7:0]     ioRdData
);
    import timer0_pkg::*;
    // bus idle at time zero
    initial ioReq = '0;
    // one write; data inverted once released
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        ioReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        ioReq <= '{a, ~d, 1'b0, 1'b0};
        @(posedge clk);
    endtask : wr
    // one read; data taken once settled
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        ioReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        ioReq.rd <= 1'b0;
        repeat (2) @(posedge clk);
        d = ioRdData;
    endtask : rd
    // high byte first, back to back, pair never interrupted
    task automatic wr16(input logic [5:0] h, l, input logic [15:0] v);
        @(posedge clk);
        ioReq <= '{h, v[15:8], 1'b1, 1'b0};
        @(posedge clk);
        ioReq <= '{l, v[7:0], 1'b1, 1'b0};
        @(posedge clk);
        ioReq <= '{l, ~v[7:0], 1'b0, 1'b0};
        @(posedge clk);
    endtask : wr16
endmodule : cpu_bus_model

// ==== bench/timer0_capture_and_wide_access_tb_top.sv ====
// Purpose: self-checking bench for timer0_core
// Assumes: timer clock enable pulsed by hand
// Notes:   capture delay judged by what the filter adds
`timescale 1ns/1ps
module timer0_capture_and_wide_access_tb_top;
    import timer0_pkg::*;
    logic        clk = 0;
    logic        rst_b = 0;
    logic        tickEn = 0;
    logic        pin = 0;
    logic        comp = 0;
    io_req_s     req;
    logic [7:0]  rdData, irq, d;
    logic [15:0] cnt;
    int          fail_count = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          n0, n;
    timer0_core dut (.clk(clk), .rst_b(rst_b), .ioReq(req),
        .ioRdData(rdData), .tickEn(tickEn), .captureInputPin(pin),
        .comparatorOut(comp), .irqRequest(irq), .countReg(cnt));
    cpu_bus_model cpu (.clk(clk), .ioReq(req), .ioRdData(rdData));
    // system clock
    initial begin
        forever #5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    // new control value, then drop any stray capture
    task automatic setc(input logic [7:0] v);
        cpu.wr(ADDR_CTRL_A, v);
        repeat (12) @(posedge clk);
        cpu.wr(ADDR_FLAGS, 8'h01);
    endtask : setc
    // move one source, count cycles to capture request
    task automatic lat(input logic src, v, output int k);
        @(posedge clk);
        if (src) comp <= v;
        else pin <= v;
        k = 0;
        while (irq[0] !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        cpu.wr(ADDR_FLAGS, 8'h01);
        repeat (2) @(posedge clk);
    endtask : lat
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk);
            tickEn <= 1'b1;
            @(posedge clk);
            tickEn <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask : tick
    task automatic test_regs;
        cpu.rd(ADDR_CTRL_A, d);
        chk("ctrlReset", {8'h00, d}, 16'h0000);
        cpu.wr(ADDR_CTRL_A, 8'hFF);
        cpu.rd(ADDR_CTRL_A, d);
        chk("ctrlRsvd", {8'h00, d}, 16'h00F9);
        cpu.wr(ADDR_CTRL_A, 8'h80);
        cpu.wr16(ADDR_CNT_HIGH, ADDR_CNT_LOW, 16'h01FF);
        chk("cnt16", cnt, 16'h01FF);
        cpu.wr(ADDR_CNT_LOW, 8'h34);
        chk("tempKept", cnt, 16'h0134);
        cpu.rd(ADDR_CNT_LOW, d);
        chk("rdLow", {8'h00, d}, 16'h0034);
        cpu.rd(ADDR_CNT_HIGH, d);
        chk("rdHigh", {8'h00, d}, 16'h0001);
    endtask : test_regs
    task automatic test_capture;
        cpu.wr(ADDR_MASK, 8'h01);
        setc(8'hD0);
        lat(0, 1, n0);
        chk("capRise", 16'(n0 < 20), 16'h0001);
        cpu.rd(ADDR_CMP_A, d);
        chk("capLow", {8'h00, d}, 16'h0034);
        cpu.rd(ADDR_CMP_B, d);
        chk("capHigh", {8'h00, d}, 16'h0001);
        setc(8'hF0);
        lat(0, 0, n);
        chk("wrongEdge", 16'(n), 16'h0014);
        lat(0, 1, n);
        chk("filterLat", 16'(n - n0), 16'h0004);
        setc(8'hC8);
        lat(1, 1, n);
        lat(1, 0, n);
        chk("compSrc", 16'(n < 20), 16'h0001);
        setc(8'hC0);
        lat(1, 1, n);
        lat(1, 0, n);
        chk("compCut", 16'(n), 16'h0014);
        setc(8'h80);
        lat(0, 0, n);
        chk("capOff", 16'(n), 16'h0014);
        // capture with its enable cleared must not request
        setc(8'hD0);
        cpu.wr(ADDR_MASK, 8'h00);
        lat(0, 1, n);
        chk("capMasked", 16'(n), 16'h0014);
    endtask : test_capture
    task automatic test_compare;
        setc(8'h00);
        cpu.wr(ADDR_MASK, 8'h10);
        cpu.wr(ADDR_CMP_A, 8'h05);
        cpu.wr(ADDR_CNT_LOW, 8'h05);
        chk("cnt8", cnt, 16'h0005);
        tick(3);
        chk("blocked", {15'h0, irq[4]}, 16'h0000);
        cpu.wr(ADDR_CNT_LOW, 8'h04);
        tick(2);
        chk("notYet", {15'h0, irq[4]}, 16'h0000);
        tick(1);
        chk("hitA", {15'h0, irq[4]}, 16'h0001);
        // clear on compare: count returns to zero at the top
        setc(8'h01);
        cpu.wr(ADDR_CNT_LOW, 8'h04);
        tick(2);
        chk("ctcTop", cnt, 16'h0000);
        tick(1);
        // 16-bit compare: only the full value may match
        setc(8'h80);
        cpu.wr(ADDR_FLAGS, 8'h10);
        cpu.wr16(ADDR_CMP_B, ADDR_CMP_A, 16'h0102);
        cpu.wr16(ADDR_CNT_HIGH, ADDR_CNT_LOW, 16'h0001);
        tick(3);
        chk("cmp16Low", {15'h0, irq[4]}, 16'h0000);
        cpu.wr16(ADDR_CNT_HIGH, ADDR_CNT_LOW, 16'h0101);
        tick(3);
        chk("cmp16Hit", {15'h0, irq[4]}, 16'h0001);
    endtask : test_compare
    task automatic end_of_test;
        $display("checks %0d fails %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // reset, then scenarios in turn
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        test_regs();
        test_capture();
        test_compare();
        end_of_test();
    end
endmodule : timer0_capture_and_wide_access_tb_top
